// >>> gbc_config.sv
// gate bias config: registers, sample filtering and calculation triggers
`timescale 1ns/1ps
module gbc_config
    import gbc_pkg::*;
(
    input wire logic clk_sys, // system clock, 20 MHz
    input wire logic sys_rst, // synchronous reset, active high
    // host register port
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    input wire logic [1:0] reg_sel, // register select
    input wire logic [15:0] reg_wdata, // write data
    output logic [15:0] reg_rdata, // read data, one cycle after read
    // measurement samples
    input wire logic [1:0] ext_temp_valid, // remote sensor sample strobe
    input wire logic [1:0][11:0] ext_temp_data, // remote sensor samples
    input wire logic int_temp_valid, // die sensor sample strobe
    input wire logic [11:0] int_temp_data, // die sensor sample
    input wire logic [1:0] drain_valid, // drain current sample strobe
    input wire logic [1:0][11:0] drain_data, // drain current samples
    input wire logic [1:0] aux_valid, // auxiliary input sample strobe
    input wire logic [1:0][11:0] aux_data, // auxiliary input samples
    // calculation engine side
    output logic [1:0] calc_trigger, // one-cycle calculation request
    output logic [1:0] load_input_only, // 1: result to DAC input only
    output logic [1:0] temp_comp_en, // temperature term included
    output logic [1:0] apc_comp_en, // APC term included
    output logic [1:0][11:0] temp_param, // temperature value in use
    output logic [1:0][11:0] apc_lut_ptr, // APC table pointer in use
    // alarm block side
    output logic [1:0] temp_alarm_en, // temperature alarm enable
    output logic [1:0] temp_alarm_window, // 1: window, 0: hysteresis
    output logic [1:0] current_alarm_en, // current alarm enable
    output logic [1:0] current_alarm_window // 1: window, 0: hysteresis
);
    typedef struct packed {
        logic [1:0][15:0] hist_apc;
        logic [11:0] alarm_cfg;
        logic [15:0] calc_cfg;
        logic [15:0] rdata;
        logic [1:0][11:0] last_temp;
        logic [1:0] last_temp_ok;
        logic [1:0][11:0] last_apc;
        logic [1:0] last_apc_ok;
        logic [1:0] trig;
        logic [1:0][11:0] temp_par;
        logic [1:0][11:0] lut_ptr;
    } gbc_cfg_state_t;

    gbc_cfg_state_t q, d;

    // filter inputs and outputs per channel
    logic [1:0] tf_in_vld;
    logic [1:0][11:0] tf_in_data;
    logic [1:0] tf_en;
    logic [1:0] tf_eq;
    logic [1:0][2:0] tf_lim;
    logic [1:0] tf_vld;
    logic [1:0][11:0] tf_data;
    logic [1:0] af_in_vld;
    logic [1:0][11:0] af_in_data;
    logic [1:0] af_en;
    logic [1:0] af_vld;
    logic [1:0][11:0] af_data;

    // source field of a channel in the calc/source register
    function automatic logic [1:0] apc_src(input logic [15:0] cfg, input int c);
        apc_src = cfg[c*SC_CH_STRIDE+SC_SRC_LSB +: 2];
    endfunction

    // per-channel sample routing and filters
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            // temperature source follows the sensor select bit
            always_comb begin
                if (q.calc_cfg[ch*SC_CH_STRIDE+SC_TSRC]) begin
                    tf_in_vld[ch] = int_temp_valid;
                    tf_in_data[ch] = int_temp_data;
                end else begin
                    tf_in_vld[ch] = ext_temp_valid[ch];
                    tf_in_data[ch] = ext_temp_data[ch];
                end
            end

            // APC source follows the source field, 00 and 01 feed no samples
            always_comb begin
                af_in_vld[ch] = 1'b0;
                af_in_data[ch] = 12'h000;
                case (apc_src(q.calc_cfg, ch))
                    SRC_DRAIN: begin
                        af_in_vld[ch] = drain_valid[ch];
                        af_in_data[ch] = drain_data[ch];
                    end
                    SRC_AUX: begin
                        af_in_vld[ch] = aux_valid[ch];
                        af_in_data[ch] = aux_data[ch];
                    end
                    default: begin
                        af_in_vld[ch] = 1'b0;
                        af_in_data[ch] = 12'h000;
                    end
                endcase
            end

            // filter enables from the write-only alarm/filter bits
            assign tf_en[ch] = q.alarm_cfg[AL_TAVG+ch*AL_AVG_STRIDE];
            assign af_en[ch] = q.alarm_cfg[AL_AAVG+ch*AL_AVG_STRIDE];

            gbc_avg_filter u_temp_flt (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .enable(tf_en[ch]),
                .equation(tf_eq[ch]),
                .limit(tf_lim[ch]),
                .smp_valid(tf_in_vld[ch]),
                .smp_data(tf_in_data[ch]),
                .out_valid(tf_vld[ch]),
                .out_data(tf_data[ch])
            );

            // APC averaging controls live in the register only in 1x mode
            gbc_avg_filter u_apc_flt (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .enable(af_en[ch]),
                .equation(q.hist_apc[ch][HA_AEQ_BIT]),
                .limit(q.hist_apc[ch][HA_ALIMIT_LSB +: 3]),
                .smp_valid(af_in_vld[ch]),
                .smp_data(af_in_data[ch]),
                .out_valid(af_vld[ch]),
                .out_data(af_data[ch])
            );
        end
    endgenerate

    // channel 2 temperature filter takes its controls from the config register
    assign tf_eq[0] = 1'b0;
    assign tf_lim[0] = 3'h0;
    assign tf_eq[1] = q.calc_cfg[SC_T2EQ_BIT];
    assign tf_lim[1] = q.calc_cfg[SC_T2LIM_LSB +: 3];

    // next state: register writes, reads and trigger evaluation
    always_comb begin
        logic [1:0] src;
        logic tcomp;
        logic acomp;
        logic [3:0] thyst;
        logic [3:0] ahyst;
        src = 2'h0;
        tcomp = 1'b0;
        acomp = 1'b0;
        thyst = 4'h0;
        ahyst = 4'h0;
        d = q;
        d.trig = 2'h0;

        // host writes; reset leaves every field cleared
        if (reg_wr) begin
            case (reg_sel)
                SEL_HIST_APC_CH1: d.hist_apc[0] = reg_wdata;
                SEL_HIST_APC_CH2: d.hist_apc[1] = reg_wdata;
                SEL_ALARM_FILTER: d.alarm_cfg = reg_wdata[11:0];
                SEL_CALC_SOURCE: d.calc_cfg = reg_wdata;
                default: d.calc_cfg = q.calc_cfg;
            endcase
        end

        // host reads; write-only bits read back as zero
        if (reg_rd) begin
            case (reg_sel)
                SEL_HIST_APC_CH1: d.rdata = q.hist_apc[0];
                SEL_HIST_APC_CH2: d.rdata = q.hist_apc[1];
                SEL_ALARM_FILTER:
                    d.rdata = {4'h0, q.alarm_cfg & AL_READ_MASK};
                SEL_CALC_SOURCE:
                    d.rdata = q.calc_cfg & SC_READ_MASK;
                default: d.rdata = 16'h0000;
            endcase
        end

        // each channel evaluated on its own settings only
        for (int c = 0; c < NUM_CH; c++) begin
            src = apc_src(q.calc_cfg, c);
            tcomp = q.calc_cfg[c*SC_CH_STRIDE+SC_TCOMP];
            acomp = q.calc_cfg[c*SC_CH_STRIDE+SC_APCCOMP];
            thyst = q.hist_apc[c][HA_THYST_LSB +: 4];
            ahyst = q.hist_apc[c][HA_AHYST_LSB +: 4];

            // temperature sample beyond hysteresis starts a calculation
            if (tf_vld[c] && tcomp) begin
                if (!q.last_temp_ok[c] ||
                    exceeds(tf_data[c], q.last_temp[c], thyst)) begin
                    d.trig[c] = 1'b1;
                    d.last_temp[c] = tf_data[c];
                    d.last_temp_ok[c] = 1'b1;
                    d.temp_par[c] = tf_data[c];
                end
            end

            // measured APC sample beyond its hysteresis starts a calculation
            if (src[1] && af_vld[c] && acomp) begin
                if (!q.last_apc_ok[c] ||
                    exceeds(af_data[c], q.last_apc[c], ahyst)) begin
                    d.trig[c] = 1'b1;
                    d.last_apc[c] = af_data[c];
                    d.last_apc_ok[c] = 1'b1;
                    d.lut_ptr[c] = af_data[c];
                end
            end

            // stored APC parameter is the pointer while source bit 1 is 0
            if (!src[1]) begin
                d.lut_ptr[c] = d.hist_apc[c][HA_APC_LSB +: 12];
                d.last_apc_ok[c] = 1'b0;
            end

            // a parameter write counts only in stored-parameter mode
            if (reg_wr && reg_sel == (c == 0 ? SEL_HIST_APC_CH1
                                              : SEL_HIST_APC_CH2)) begin
                if (!src[1] && acomp) begin
                    d.trig[c] = 1'b1;
                end
            end

            // leaving temperature compensation forgets the last used sample
            if (!tcomp) begin
                d.last_temp_ok[c] = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '0;
            q.hist_apc[0] <= HIST_APC_RST;
            q.hist_apc[1] <= HIST_APC_RST;
            q.alarm_cfg <= ALARM_FILTER_RST;
            q.calc_cfg <= CALC_SOURCE_RST;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = q.rdata;
    assign calc_trigger = q.trig;
    assign temp_param = q.temp_par;
    assign apc_lut_ptr = q.lut_ptr;

    // configuration bits fanned out per channel
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_out
            assign load_input_only[ch] =
                q.calc_cfg[ch*SC_CH_STRIDE+SC_LDAC];
            assign temp_comp_en[ch] =
                q.calc_cfg[ch*SC_CH_STRIDE+SC_TCOMP];
            assign apc_comp_en[ch] =
                q.calc_cfg[ch*SC_CH_STRIDE+SC_APCCOMP];
            assign temp_alarm_en[ch] =
                q.alarm_cfg[ch*AL_CH_STRIDE+AL_TEN];
            assign temp_alarm_window[ch] =
                q.alarm_cfg[ch*AL_CH_STRIDE+AL_TWIN];
            assign current_alarm_en[ch] =
                q.alarm_cfg[ch*AL_CH_STRIDE+AL_IEN];
            assign current_alarm_window[ch] =
                q.alarm_cfg[ch*AL_CH_STRIDE+AL_IWIN];
        end
    endgenerate
endmodule

// >>> gbc_pkg.sv
// package: register layout, reset values and helpers for the gate bias config
// Contract
// - APC source 00: per-channel register holds APC parameter plus temperature hysteresis.
// - APC source 10/11: register holds APC averaging/hysteresis controls plus temp hysteresis.
// - New temperature sample triggers calculation only if it differs by more than hysteresis.
// - APC parameter becomes the APC table pointer, used only while source bit 1 is 0.
// - APC parameter write triggers calculation when source bit 1 is 0 and APC comp on.
// - Tracking adds one sixteenth of difference (equation 0) or one quarter (equation 1).
// - Initial average takes exactly 16 samples; equation and limiter do not affect it.
// - Tracking computes sample minus average, clamps per limiter, then adds scaled result.
// - APC limiter has no effect unless APC averaging is enabled for that channel.
// - Alarm bits 11..8 enable ch2 APC, ch2 temp, ch1 APC, ch1 temp filters; write only.
// - Averaged temperature follows temp sensor select; averaged APC follows APC source.
// - Alarm bits 7,5,3,1 enable ch2 temp, ch2 current, ch1 temp, ch1 current alarms.
// - Alarm mode bits 6,4,2,0: 0 hysteresis mode, 1 window mode.
// - Config bit 15 selects ch2 temp equation, bits 14..12 its limiter; write only, reset 0.
// - Load bits 11 and 5: 0 loads DAC input and output, 1 input register only.
// - Temperature compensation bits 10 and 4 let temperature samples trigger calculations.
// - APC compensation bits 9 and 3 let current samples or APC writes trigger calculations.
// - Temperature select bits 8 and 2: 0 remote external sensor, 1 internal die sensor.
// - APC source fields at bits 7:6 (ch2) and 1:0 (ch1), reset to 00.
// - APC source: 00 stored parameter, 01 reserved, 10 drain current, 11 auxiliary input.
// - Limiter codes 0..7: none, then 1, 3, 7, 15, 31, 63, 127 LSB clamps.
package gbc_pkg;
    localparam int NUM_CH = 2;
    localparam int DATA_W = 12;
    localparam int REG_W = 16;

    // register select codes on the host register port
    localparam logic [1:0] SEL_HIST_APC_CH1 = 2'h0;
    localparam logic [1:0] SEL_HIST_APC_CH2 = 2'h1;
    localparam logic [1:0] SEL_ALARM_FILTER = 2'h2;
    localparam logic [1:0] SEL_CALC_SOURCE = 2'h3;

    // reset values
    localparam logic [15:0] HIST_APC_RST = 16'h0000;
    localparam logic [11:0] ALARM_FILTER_RST = 12'h000;
    localparam logic [15:0] CALC_SOURCE_RST = 16'h0000;

    // hysteresis/APC register fields
    localparam int HA_THYST_LSB = 0;
    localparam int HA_AHYST_LSB = 4;
    localparam int HA_APC_LSB = 4;
    localparam int HA_ALIMIT_LSB = 12;
    localparam int HA_AEQ_BIT = 15;

    // alarm/filter register fields, channel stride 4 for alarms, 2 for filters
    localparam int AL_IWIN = 0;
    localparam int AL_IEN = 1;
    localparam int AL_TWIN = 2;
    localparam int AL_TEN = 3;
    localparam int AL_CH_STRIDE = 4;
    localparam int AL_TAVG = 8;
    localparam int AL_AAVG = 9;
    localparam int AL_AVG_STRIDE = 2;
    localparam logic [11:0] AL_READ_MASK = 12'h0ff;

    // calc source/trigger register fields, channel stride 6
    localparam int SC_SRC_LSB = 0;
    localparam int SC_TSRC = 2;
    localparam int SC_APCCOMP = 3;
    localparam int SC_TCOMP = 4;
    localparam int SC_LDAC = 5;
    localparam int SC_CH_STRIDE = 6;
    localparam int SC_T2LIM_LSB = 12;
    localparam int SC_T2EQ_BIT = 15;
    localparam logic [15:0] SC_READ_MASK = 16'h0fff;

    // APC source encodings
    localparam logic [1:0] SRC_PARAM = 2'h0;
    localparam logic [1:0] SRC_RSVD = 2'h1;
    localparam logic [1:0] SRC_DRAIN = 2'h2;
    localparam logic [1:0] SRC_AUX = 2'h3;

    // initial average acquisition
    localparam logic [4:0] ACQ_LAST = 5'h0f;
    localparam int ACQ_SHIFT = 4;

    // clamp in LSBs for a limiter code, zero meaning no limiting
    function automatic logic [7:0] limit_lsbs(input logic [2:0] code);
        limit_lsbs = (8'h01 << code) - 8'h01;
    endfunction

    // true when two samples differ by more than the hysteresis
    function automatic logic exceeds(input logic [11:0] a, input logic [11:0] b,
                                     input logic [3:0] h);
        logic [11:0] mag;
        mag = (a > b) ? (a - b) : (b - a);
        exceeds = mag > {8'h00, h};
    endfunction
endpackage

// >>> gbc_avg_filter.sv
// averaging filter: 16-sample acquisition then limited tracking average
`timescale 1ns/1ps
module gbc_avg_filter
    import gbc_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic enable, // averaging enabled
    input wire logic equation, // 0: 1/16 step, 1: 1/4 step
    input wire logic [2:0] limit, // difference limiter code
    input wire logic smp_valid, // new sample strobe
    input wire logic [11:0] smp_data, // new sample
    output logic out_valid, // filtered sample strobe
    output logic [11:0] out_data // filtered sample
);
    typedef struct packed {
        logic [4:0] acq_cnt;
        logic [15:0] acc;
        logic [11:0] avg;
        logic avg_ok;
        logic [11:0] out;
        logic out_vld;
    } gbc_flt_state_t;

    gbc_flt_state_t q, d;

    // next state of the filter
    always_comb begin
        logic [15:0] sum;
        logic signed [12:0] diff;
        logic signed [12:0] lim;
        logic signed [12:0] step;
        logic [11:0] navg;
        sum = q.acc + {4'h0, smp_data};
        diff = $signed({1'b0, smp_data}) - $signed({1'b0, q.avg});
        lim = $signed({5'h00, limit_lsbs(limit)});
        step = 13'sh0;
        navg = q.avg;
        d = q;
        d.out_vld = 1'b0;
        if (!enable) begin
            // disabled: raw samples pass, limiter has no effect
            d.acq_cnt = 5'h00;
            d.acc = 16'h0000;
            d.avg_ok = 1'b0;
            if (smp_valid) begin
                d.out = smp_data;
                d.out_vld = 1'b1;
            end
        end else if (smp_valid && !q.avg_ok) begin
            // acquisition ignores equation and limiter
            d.acc = sum;
            if (q.acq_cnt == ACQ_LAST) begin
                navg = sum[15:ACQ_SHIFT];
                d.avg = navg;
                d.avg_ok = 1'b1;
                d.out = navg;
                d.out_vld = 1'b1;
            end else begin
                d.acq_cnt = q.acq_cnt + 5'h01;
            end
        end else if (smp_valid) begin
            // tracking: symmetric clamp then scaled add
            if (limit != 3'h0) begin
                if (diff > lim) begin
                    diff = lim;
                end else if (diff < -lim) begin
                    diff = -lim;
                end
            end
            step = equation ? (diff >>> 2) : (diff >>> 4);
            navg = 12'(q.avg + step[11:0]);
            d.avg = navg;
            d.out = navg;
            d.out_vld = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign out_valid = q.out_vld;
    assign out_data = q.out;
endmodule

// >>> gbc_properties.sv
// checker: port-level properties of the gate bias config block
`timescale 1ns/1ps
module gbc_properties
    import gbc_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [1:0] reg_sel, // register select
    input wire logic [15:0] reg_wdata, // write data
    input wire logic [15:0] reg_rdata, // read data
    input wire logic [1:0] calc_trigger, // calculation request
    input wire logic [1:0] load_input_only, // result load mode
    input wire logic [1:0] temp_comp_en, // temperature term enable
    input wire logic [1:0] apc_comp_en, // apc term enable
    input wire logic [1:0][11:0] apc_lut_ptr, // apc pointer
    input wire logic [1:0] temp_alarm_en, // temp alarm enable
    input wire logic [1:0] temp_alarm_window, // temp alarm mode
    input wire logic [1:0] current_alarm_en, // current alarm enable
    input wire logic [1:0] current_alarm_window // current alarm mode
);
    logic src1_hi_q; // shadow of channel 1 apc source bit 1
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // shadow the source select, since it has no port of its own
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            src1_hi_q <= 1'b0;
        end else if (reg_wr && reg_sel == SEL_CALC_SOURCE) begin
            src1_hi_q <= reg_wdata[1];
        end
    end
    // host write and trigger steps
    sequence s_cfg_wr;
        reg_wr && reg_sel == SEL_CALC_SOURCE;
    endsequence
    sequence s_alm_wr;
        reg_wr && reg_sel == SEL_ALARM_FILTER;
    endsequence
    sequence s_param_wr;
        reg_wr && reg_sel == SEL_HIST_APC_CH1 && !src1_hi_q && apc_comp_en[0];
    endsequence
    sequence s_trig_out;
        calc_trigger[0] && apc_lut_ptr[0] == $past(reg_wdata[15:4]);
    endsequence
    chk_reset_quiet: assert property ($fell(sys_rst) |->
        calc_trigger == 2'h0 && load_input_only == 2'h0 && apc_comp_en == 2'h0)
        else $error("outputs not cleared by reset");
    chk_load_mode: assert property (s_cfg_wr |=>
        load_input_only == {$past(reg_wdata[11]), $past(reg_wdata[5])})
        else $error("load mode does not follow write");
    chk_temp_comp: assert property (s_cfg_wr |=>
        temp_comp_en == {$past(reg_wdata[10]), $past(reg_wdata[4])})
        else $error("temperature enable does not follow write");
    chk_apc_comp: assert property (s_cfg_wr |=>
        apc_comp_en == {$past(reg_wdata[9]), $past(reg_wdata[3])})
        else $error("apc enable does not follow write");
    chk_alarm_en: assert property (s_alm_wr |=>
        temp_alarm_en == {$past(reg_wdata[7]), $past(reg_wdata[3])} &&
        current_alarm_en == {$past(reg_wdata[5]), $past(reg_wdata[1])})
        else $error("alarm enables do not follow write");
    chk_alarm_mode: assert property (s_alm_wr |=>
        temp_alarm_window == {$past(reg_wdata[6]), $past(reg_wdata[2])} &&
        current_alarm_window == {$past(reg_wdata[4]), $past(reg_wdata[0])})
        else $error("alarm modes do not follow write");
    chk_param_trig: assert property (s_param_wr |=> s_trig_out)
        else $error("parameter write did not trigger");
    chk_cfg_wonly: assert property (reg_rd && reg_sel[1] |=>
        reg_rdata[15:12] == 4'h0)
        else $error("write-only upper bits read back");
    chk_filt_wonly: assert property (
        reg_rd && reg_sel == SEL_ALARM_FILTER |=> reg_rdata[11:8] == 4'h0)
        else $error("filter enables read back");
    chk_no_comp_trig: assert property (
        (!temp_comp_en[0] && !apc_comp_en[0])[*3] |-> !calc_trigger[0])
        else $error("trigger with compensation off");
endmodule

// >>> testbench.sv
// testbench: register and sample-trigger tests for the gate bias config
`timescale 1ns/1ps
module testbench
    import gbc_pkg::*;
;
    logic clk_sys, sys_rst, reg_wr, reg_rd, int_temp_valid;
    logic [1:0] reg_sel, ext_temp_valid, drain_valid, aux_valid, calc_trigger;
    logic [15:0] reg_wdata, reg_rdata;
    logic [11:0] int_temp_data;
    logic [1:0][11:0] ext_temp_data, drain_data, aux_data;
    logic [1:0][11:0] temp_param, apc_lut_ptr;
    logic [1:0] load_input_only, temp_comp_en, apc_comp_en, temp_alarm_en;
    logic [1:0] temp_alarm_window, current_alarm_en, current_alarm_window;
    int miscompares = 0;
    int n_compared = 0;
    logic [15:0] cv [3] = '{16'hf824, 16'h0618, 16'h0000};
    logic [15:0] av [3] = '{16'hffff, 16'h0f5a, 16'h00a5};
    // rows: source cfg, strobes, temp, apc, count, trig, exp temp, exp ptr
    logic [75:0] tbl_a [12] = '{76'h0010_1_100_000_1_1_100_000,
        76'h0010_1_104_000_1_0_000_000, 76'h0010_1_105_000_1_1_105_000,
        76'h0010_2_200_000_1_0_000_000, 76'h0010_1_0fd_000_1_1_0fd_000,
        76'h0014_2_200_000_1_1_200_000, 76'h0014_1_300_000_1_0_000_000,
        76'h0000_1_400_000_1_0_000_000, 76'h0280_4_000_321_1_2_000_321,
        76'h0280_8_000_654_1_0_000_000, 76'h02c0_8_000_456_1_2_000_456,
        76'h02c0_4_000_777_1_0_000_000};
    logic [75:0] tbl_b [4] = '{76'hb690_5_0a0_100_f_0_000_000,
        76'hb690_5_0a0_100_1_3_0a0_100, 76'hb690_5_140_200_1_3_0aa_101,
        76'hb690_5_0aa_000_1_2_000_0ff};

    gbc_config u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ext_temp_valid(ext_temp_valid), .ext_temp_data(ext_temp_data),
        .int_temp_valid(int_temp_valid), .int_temp_data(int_temp_data),
        .drain_valid(drain_valid), .drain_data(drain_data),
        .aux_valid(aux_valid), .aux_data(aux_data),
        .calc_trigger(calc_trigger), .load_input_only(load_input_only),
        .temp_comp_en(temp_comp_en), .apc_comp_en(apc_comp_en),
        .temp_param(temp_param), .apc_lut_ptr(apc_lut_ptr),
        .temp_alarm_en(temp_alarm_en), .temp_alarm_window(temp_alarm_window),
        .current_alarm_en(current_alarm_en),
        .current_alarm_window(current_alarm_window)
    );

    task automatic tick;
        @(posedge clk_sys);
        #5;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [15:0] d);
        tick();
        reg_wr = 1'b1;
        reg_sel = s;
        reg_wdata = d;
        tick();
        reg_wr = 1'b0;
    endtask
    task automatic rdc(input logic [1:0] s, input logic [15:0] exp);
        tick();
        reg_rd = 1'b1;
        reg_sel = s;
        tick();
        reg_rd = 1'b0;
        check(reg_rdata, exp);
    endtask
    // strobe the chosen sources, then idle data lines to the inverse value
    task automatic smp(input logic [3:0] v, input logic [11:0] x, y);
        tick();
        {ext_temp_valid, int_temp_valid} = {{2{v[0]}}, v[1]};
        {drain_valid, aux_valid} = {{2{v[2]}}, {2{v[3]}}};
        {ext_temp_data, int_temp_data} = {{2{x}}, x};
        {drain_data, aux_data} = {{2{y}}, {2{y}}};
        tick();
        {ext_temp_valid, int_temp_valid, drain_valid, aux_valid} = '0;
        {ext_temp_data, int_temp_data} = {{2{~x}}, ~x};
        {drain_data, aux_data} = {{2{~y}}, {2{~y}}};
        tick();
    endtask
    task automatic run(input logic [75:0] r);
        wr(SEL_CALC_SOURCE, r[75:60]);
        repeat (r[31:28]) begin
            smp(r[59:56], r[55:44], r[43:32]);
            check(calc_trigger, r[25:24]);
        end
        if (r[24]) check(temp_param[0], r[23:12]);
        if (r[25]) check(apc_lut_ptr[1], r[11:0]);
    endtask
    task automatic print_verdict;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // watchdog
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
    // main sequence
    initial begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, reg_sel, reg_wdata} = '0;
        {ext_temp_valid, int_temp_valid, drain_valid, aux_valid} = '0;
        {ext_temp_data, int_temp_data, drain_data, aux_data} = '0;
        repeat (2) @(posedge clk_sys);
        #5;
        sys_rst = 1'b0;
        for (int i = 0; i < 4; i++) rdc(2'(i), 16'h0000);
        foreach (cv[i]) begin
            wr(SEL_CALC_SOURCE, cv[i]);
            check(load_input_only, {cv[i][11], cv[i][5]});
            check(temp_comp_en, {cv[i][10], cv[i][4]});
            check(apc_comp_en, {cv[i][9], cv[i][3]});
            rdc(SEL_CALC_SOURCE, cv[i] & 16'h0fff);
            wr(SEL_ALARM_FILTER, av[i]);
            check(temp_alarm_en, {av[i][7], av[i][3]});
            check(current_alarm_en, {av[i][5], av[i][1]});
            check(temp_alarm_window, {av[i][6], av[i][2]});
            check(current_alarm_window, {av[i][4], av[i][0]});
            rdc(SEL_ALARM_FILTER, av[i] & 16'h00ff);
        end
        // parameter writes: trigger only with apc compensation on the stored parameter
        wr(SEL_CALC_SOURCE, 16'h0008);
        wr(SEL_HIST_APC_CH1, 16'habc0);
        check(calc_trigger, 2'h1);
        check(apc_lut_ptr[0], 12'habc);
        rdc(SEL_HIST_APC_CH1, 16'habc0);
        check(calc_trigger, 2'h0);
        wr(SEL_CALC_SOURCE, 16'h000a);
        wr(SEL_HIST_APC_CH1, 16'h1230);
        check(calc_trigger, 2'h0);
        wr(SEL_CALC_SOURCE, 16'h0000);
        wr(SEL_HIST_APC_CH1, 16'h4560);
        check(calc_trigger, 2'h0);
        // hysteresis changed only while both enables are off
        wr(SEL_HIST_APC_CH1, 16'h0004);
        wr(SEL_HIST_APC_CH2, 16'h1000);
        foreach (tbl_a[i]) run(tbl_a[i]);
        // averaging: both temperature filters and the ch2 apc filter
        wr(SEL_CALC_SOURCE, 16'h0000);
        wr(SEL_HIST_APC_CH1, 16'h0000);
        wr(SEL_HIST_APC_CH2, 16'hb000);
        rdc(SEL_HIST_APC_CH2, 16'hb000);
        wr(SEL_ALARM_FILTER, 16'h0d00);
        rdc(SEL_ALARM_FILTER, 16'h0000);
        foreach (tbl_b[i]) run(tbl_b[i]);
        check(temp_param[1], 12'h0a2);
        print_verdict();
    end
endmodule

bind gbc_config gbc_properties u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .calc_trigger(calc_trigger), .load_input_only(load_input_only),
    .temp_comp_en(temp_comp_en), .apc_comp_en(apc_comp_en),
    .apc_lut_ptr(apc_lut_ptr), .temp_alarm_en(temp_alarm_en),
    .temp_alarm_window(temp_alarm_window),
    .current_alarm_en(current_alarm_en),
    .current_alarm_window(current_alarm_window)
);
